// [verilog/dlc_regs.sv]
// configuration register bank of the display link source transmitter
`timescale 1ns/100ps
module dlc_regs #(
   parameter bit V12_BUILD = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // axi4-lite write address
   input wire logic [dlc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [dlc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [dlc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [dlc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // status from other domains
   input wire logic vid_vsync,
   input wire logic payload_updated,
   // controls toward the link core
   output dlc_pkg::dlc_cfg_t cfg,
   output logic cfg_toggle,
   output logic stream_enable,
   output logic no_video_flag,
   output dlc_pkg::dlc_pulse_t pulses
);
   import dlc_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_W-1:0] rdata;
      logic [7:0] rate;
      logic [4:0] lanes;
      logic eframe;
      logic [1:0] train;
      logic [1:0] qual;
      logic scr_byp;
      logic tx_en;
      logic vid_en_req;
      logic vid_en;
      logic mst_en;
      logic toggle;
      dlc_pulse_t pulse;
      logic [1:0] vs_sync;
      logic vs_prev;
      logic [1:0] upd_sync;
      dlc_cfg_t cfg;
   } dlc_state_t;

   dlc_state_t st_r;
   dlc_state_t st_nxt;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic known_off(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_RATE, OFF_LANES, OFF_EFRAME, OFF_TRAIN, OFF_QUAL, OFF_SCRBYP,
         OFF_SOFTRST, OFF_TXEN, OFF_VIDEN, OFF_SCRRST, OFF_MST: known_off = 1'b1;
         default: known_off = 1'b0;
      endcase
   endfunction : known_off

   function automatic dlc_rate_t rate_dec(input logic [7:0] code);
      case (code)
         RATE_162: rate_dec = DLC_RATE_162;
         RATE_270: rate_dec = DLC_RATE_270;
         RATE_540: rate_dec = V12_BUILD ? DLC_RATE_540 : DLC_RATE_BAD;
         default: rate_dec = DLC_RATE_BAD;
      endcase
   endfunction : rate_dec

   function automatic logic [3:0] lane_dec(input logic [4:0] n);
      case (n)
         LANES_1: lane_dec = 4'h1;
         LANES_2: lane_dec = 4'h3;
         LANES_4: lane_dec = 4'hf;
         default: lane_dec = 4'h0;
      endcase
   endfunction : lane_dec

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic do_wr;
   logic do_rd;
   logic [DATA_W-1:0] wd;
   logic cfg_chg;
   logic vs_rise;

   always_comb begin
      st_nxt = st_r;
      do_wr = 1'b0;
      do_rd = 1'b0;
      wd = st_r.w_data;
      cfg_chg = 1'b0;
      // pulses last one cycle only
      st_nxt.pulse = '0;
      // capture address and data independently
      if (s_axi_awvalid && !st_r.aw_held) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_held) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         do_wr = 1'b1;
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = known_off(st_r.aw_addr) ? AXI_OKAY : AXI_SLVERR;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // every field sits in byte lane 0
      if (do_wr && st_r.w_strb[0]) begin
         case (st_r.aw_addr)
            OFF_RATE: st_nxt.rate = wd[7:0];
            OFF_LANES: st_nxt.lanes = wd[4:0];
            OFF_EFRAME: st_nxt.eframe = wd[0];
            OFF_TRAIN: st_nxt.train = wd[1:0];
            OFF_QUAL: st_nxt.qual = wd[1:0];
            OFF_SCRBYP: st_nxt.scr_byp = wd[0];
            OFF_SOFTRST: begin
               st_nxt.pulse.vid_rst = wd[SR_VID_LSB +: SR_VID_N];
               st_nxt.pulse.aux_rst = wd[SR_AUX_BIT];
            end
            OFF_TXEN: st_nxt.tx_en = wd[0];
            OFF_VIDEN: st_nxt.vid_en_req = wd[0];
            OFF_SCRRST: st_nxt.pulse.scr_rst = wd[0];
            OFF_MST: st_nxt.mst_en = wd[MST_EN_BIT];
            default: st_nxt.rate = st_r.rate;
         endcase
      end
      // read channel; reserved and write-only bits read zero
      if (s_axi_arvalid && !st_r.rvalid) begin
         do_rd = 1'b1;
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = known_off(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
         st_nxt.rdata = '0;
         case (s_axi_araddr)
            OFF_RATE: st_nxt.rdata[7:0] = st_r.rate;
            OFF_LANES: st_nxt.rdata[4:0] = st_r.lanes;
            OFF_EFRAME: st_nxt.rdata[0] = st_r.eframe;
            OFF_TRAIN: st_nxt.rdata[1:0] = st_r.train;
            OFF_QUAL: st_nxt.rdata[1:0] = st_r.qual;
            OFF_SCRBYP: st_nxt.rdata[0] = st_r.scr_byp;
            OFF_TXEN: st_nxt.rdata[0] = st_r.tx_en;
            OFF_VIDEN: st_nxt.rdata[0] = st_r.vid_en_req;
            OFF_MST: begin
               st_nxt.rdata[MST_EN_BIT] = st_r.mst_en;
               // synchronised bit, single-bit so old or new is read
               st_nxt.rdata[MST_UPD_BIT] = st_r.upd_sync[1];
            end
            default: st_nxt.rdata = '0;
         endcase
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      // ------------------------------------------------------------
      // vsync gating of stream enable
      // ------------------------------------------------------------
      st_nxt.vs_sync = {st_r.vs_sync[0], vid_vsync};
      st_nxt.vs_prev = st_r.vs_sync[1];
      st_nxt.upd_sync = {st_r.upd_sync[0], payload_updated};
      vs_rise = st_r.vs_sync[1] && !st_r.vs_prev;
      if (vs_rise) begin
         st_nxt.vid_en = st_r.vid_en_req;
      end
      // ------------------------------------------------------------
      // shadow copy for the core, reloaded on change with a toggle
      // ------------------------------------------------------------
      st_nxt.cfg.rate_code = st_r.rate;
      st_nxt.cfg.rate_sel = rate_dec(st_r.rate);
      st_nxt.cfg.rate_valid = rate_dec(st_r.rate) != DLC_RATE_BAD;
      st_nxt.cfg.lane_count = st_r.lanes;
      st_nxt.cfg.lane_mask = lane_dec(st_r.lanes);
      st_nxt.cfg.enh_framing = st_r.eframe;
      st_nxt.cfg.train = dlc_train_t'(st_r.train);
      if (!V12_BUILD && st_r.train == 2'h3) begin
         st_nxt.cfg.train = DLC_TRAIN_OFF;
      end
      st_nxt.cfg.qual = dlc_qual_t'(st_r.qual);
      st_nxt.cfg.scr_bypass = st_r.scr_byp;
      st_nxt.cfg.tx_enable = st_r.tx_en;
      st_nxt.cfg.mst_enable = st_r.mst_en;
      cfg_chg = st_nxt.cfg != st_r.cfg;
      if (cfg_chg) begin
         st_nxt.toggle = !st_r.toggle;
      end
      if (do_rd && do_wr) begin
         st_nxt.toggle = st_nxt.toggle;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = !st_r.aw_held;
   assign s_axi_wready = !st_r.w_held;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rdata = st_r.rdata;
   assign cfg = st_r.cfg;
   assign cfg_toggle = st_r.toggle;
   assign stream_enable = st_r.vid_en && st_r.tx_en;
   assign no_video_flag = !st_r.vid_en;
   assign pulses = st_r.pulse;
endmodule : dlc_regs

// [verilog/dlc_pkg.sv]
// constants, register map and carrier types of the link configuration bank
// Summary of operation
// - every configuration register is read and written over the AXI4-Lite slave, one clock.
// - a changing status bit reads either old or new value, never a glitch.
// - multi-bit settings reach the core with a toggle telling it to reload.
// - undefined bits are reserved and read back as zero.
// - all registers reset to zero; only offsets are decoded.
// - rate field 0x06, 0x0a, 0x14 select 1.62, 2.7, 5.4 Gbps.
// - lane count is 1, 2 or 4; link uses exactly that many lanes.
// - enhanced framing bit 0 selects enhanced framing symbol sequence.
// - training field 00 off, 01 clock recovery, 10 eq pattern 2, 11 pattern 3.
// - quality field 00 none, 01 D10.2, 10 error rate pattern, 11 PRBS7.
// - scrambler bypass bit 0 sends all symbols unscrambled.
// - soft reset bits 0 to 3 reset video logic of streams 1 to 4.
// - soft reset bit 7 resets AUX logic; the register reads zero.
// - transmit enable zero makes every lane carry stuffing only.
// - stream enable zero sends only VB-ID with no-video flag set.
// - new stream enable takes effect only at a vertical sync boundary.
// - scrambler reset bit 0 forces scrambler reset; register reads zero.
// - multi-stream bit 0 enables multi-stream transport.
// - multi-stream bit 1 is read-only, set when sink payload table updated.
package dlc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_RATE = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_LANES = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_EFRAME = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_TRAIN = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_QUAL = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_SCRBYP = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_SOFTRST = 12'h01c;
   localparam logic [ADDR_W-1:0] OFF_TXEN = 12'h080;
   localparam logic [ADDR_W-1:0] OFF_VIDEN = 12'h084;
   localparam logic [ADDR_W-1:0] OFF_SCRRST = 12'h0c0;
   localparam logic [ADDR_W-1:0] OFF_MST = 12'h0d0;
   // ------------------------------------------------------------
   // field values
   // ------------------------------------------------------------
   localparam logic [7:0] RATE_162 = 8'h06;
   localparam logic [7:0] RATE_270 = 8'h0a;
   localparam logic [7:0] RATE_540 = 8'h14;
   localparam logic [4:0] LANES_1 = 5'h01;
   localparam logic [4:0] LANES_2 = 5'h02;
   localparam logic [4:0] LANES_4 = 5'h04;
   localparam int SR_VID_LSB = 0;
   localparam int SR_VID_N = 4;
   localparam int SR_AUX_BIT = 7;
   localparam int MST_EN_BIT = 0;
   localparam int MST_UPD_BIT = 1;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [1:0] {DLC_TRAIN_OFF, DLC_TRAIN_CR, DLC_TRAIN_EQ2, DLC_TRAIN_EQ3}
      dlc_train_t;
   typedef enum logic [1:0] {DLC_QUAL_NONE, DLC_QUAL_D102, DLC_QUAL_SER, DLC_QUAL_PRBS7}
      dlc_qual_t;
   typedef enum logic [1:0] {DLC_RATE_162, DLC_RATE_270, DLC_RATE_540, DLC_RATE_BAD}
      dlc_rate_t;
   // settings handed to the link core as one word
   typedef struct packed {
      logic [7:0] rate_code;
      dlc_rate_t rate_sel;
      logic rate_valid;
      logic [4:0] lane_count;
      logic [3:0] lane_mask;
      logic enh_framing;
      dlc_train_t train;
      dlc_qual_t qual;
      logic scr_bypass;
      logic tx_enable;
      logic mst_enable;
   } dlc_cfg_t;
   // one-cycle reset pulses
   typedef struct packed {
      logic [SR_VID_N-1:0] vid_rst;
      logic aux_rst;
      logic scr_rst;
   } dlc_pulse_t;
endpackage : dlc_pkg

// [verilog/dlc_link_config_regs.sv]
// spare name of the configuration bank; it holds no module, the bank is dlc_regs


// [verif/dlc_regs_props.sv]
// concurrent property checker for the link configuration bank
`timescale 1ns/100ps
module dlc_regs_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // axi4-lite handshakes
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [dlc_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // link side
   input wire logic vid_vsync,
   input wire dlc_pkg::dlc_cfg_t cfg,
   input wire logic cfg_toggle,
   input wire logic stream_enable,
   input wire logic no_video_flag,
   input wire dlc_pkg::dlc_pulse_t pulses
);
   import dlc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer moved");
   property p_pulse;
      (pulses != '0) |=> (pulses == '0);
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse too long");
   property p_nv;
      stream_enable |-> !no_video_flag;
   endproperty
   a_nv: assert property (p_nv) else $error("video sent with flag");
   property p_tx;
      stream_enable |-> ##[0:1] cfg.tx_enable;
   endproperty
   a_tx: assert property (p_tx) else $error("stream without transmit");
   property p_toggle;
      $changed(cfg) |-> $changed(cfg_toggle);
   endproperty
   a_toggle: assert property (p_toggle) else $error("settings moved silently");
   property p_lane;
      (cfg.lane_count == LANES_2) |-> (cfg.lane_mask == 4'h3);
   endproperty
   a_lane: assert property (p_lane) else $error("lane mask wrong");
   property p_frame;
      $changed(no_video_flag) |-> $past(vid_vsync, 3) || $past(vid_vsync, 4);
   endproperty
   a_frame: assert property (p_frame) else $error("enable moved mid frame");
endmodule : dlc_regs_chk

bind dlc_regs dlc_regs_chk u_dlc_regs_chk (.mclk(mclk), .sys_rst(sys_rst),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .vid_vsync(vid_vsync), .cfg(cfg), .cfg_toggle(cfg_toggle),
   .stream_enable(stream_enable), .no_video_flag(no_video_flag), .pulses(pulses));

// [verif/dlc_host_model.sv]
// host model speaking axi4-lite to the configuration bank
`timescale 1ns/100ps
module dlc_host_model (
   // clock
   input wire logic mclk,
   // write channels
   output logic [dlc_pkg::ADDR_W-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [dlc_pkg::DATA_W-1:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read channels
   output logic [dlc_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [dlc_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   // a bounded wait ran out
   output logic hung
);
   import dlc_pkg::*;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
   end
   // ready is registered, so its settled value tells what the next edge takes
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = {a, d, 4'hf, 2'h3};
      s_axi_bready = 1'b1;
      while ((s_axi_awvalid || s_axi_wvalid) && n < 50) begin
         aw_ok = s_axi_awready;
         w_ok = s_axi_wready;
         @(posedge mclk);
         #1;
         if (aw_ok) s_axi_awvalid = 1'b0;
         if (w_ok) s_axi_wvalid = 1'b0;
         n++;
      end
      while (!s_axi_bvalid && n < 50) begin
         @(posedge mclk);
         #1;
         n++;
      end
      r = s_axi_bresp;
      @(posedge mclk);
      #1;
      s_axi_bready = 1'b0;
      if (n >= 50) hung = 1'b1;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
      output logic [1:0] r);
      logic ok;
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = {a, 2'h3};
      do begin
         ok = s_axi_arready;
         @(posedge mclk);
         #1;
         n++;
      end while (!ok && n < 50);
      s_axi_arvalid = 1'b0;
      while (!s_axi_rvalid && n < 50) begin
         @(posedge mclk);
         #1;
         n++;
      end
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge mclk);
      #1;
      s_axi_rready = 1'b0;
      if (n >= 50) hung = 1'b1;
   endtask : rd
endmodule : dlc_host_model

// [verif/dlc_regs_tb.sv]
// self-checking bench of the link configuration bank
`timescale 1ns/100ps
module dlc_regs_tb;
   import dlc_pkg::*;
   typedef struct {logic [ADDR_W-1:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} dlc_row_t;
   dlc_row_t rows [12] = '{'{OFF_RATE, 32'hffffff14, 32'h14, AXI_OKAY},
      '{OFF_LANES, 32'hffffffe4, 32'h4, AXI_OKAY}, '{OFF_EFRAME, '1, 32'h1, AXI_OKAY},
      '{OFF_TRAIN, 32'hfffffffe, 32'h2, AXI_OKAY}, '{OFF_QUAL, 32'hfffffffd, 32'h1, AXI_OKAY},
      '{OFF_SCRBYP, '1, 32'h1, AXI_OKAY}, '{OFF_SOFTRST, 32'h81, 32'h0, AXI_OKAY},
      '{OFF_TXEN, '1, 32'h1, AXI_OKAY}, '{OFF_VIDEN, '1, 32'h1, AXI_OKAY},
      '{OFF_SCRRST, '1, 32'h0, AXI_OKAY}, '{OFF_MST, 32'hfffffffd, 32'h1, AXI_OKAY},
      '{12'h020, '1, 32'h0, AXI_SLVERR}};
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic vid_vsync = 1'b0;
   logic payload_updated = 1'b0;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, hung, cfg_toggle, stream_enable, no_video_flag, tg;
   dlc_cfg_t cfg;
   dlc_pulse_t pulses, seen;
   int n_fail, total_checks, cnt;
   initial forever #12.5 mclk = ~mclk;
   dlc_regs u_dlc_regs (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .vid_vsync(vid_vsync), .payload_updated(payload_updated), .cfg(cfg),
      .cfg_toggle(cfg_toggle), .stream_enable(stream_enable),
      .no_video_flag(no_video_flag), .pulses(pulses));
   dlc_host_model u_dlc_host_model (.mclk(mclk), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .hung(hung));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         n_fail++;
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   // pulses are one cycle wide, so they are gathered over a window
   task automatic pulse_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input dlc_pulse_t e);
      seen = '0;
      cnt = 0;
      fork
         u_dlc_host_model.wr(a, d, rsp);
         repeat (8) begin
            @(posedge mclk);
            #2;
            seen |= pulses;
            if (pulses != '0) cnt++;
         end
      join
      chk(seen, e);
      chk(cnt, 1);
   endtask : pulse_chk
   always @(posedge hung) begin
      n_fail++;
      end_sim();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      n_fail = 0;
      total_checks = 0;
      repeat (4) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      chk(cfg, '0);
      chk(no_video_flag, 1);
      foreach (rows[i]) begin
         u_dlc_host_model.rd(rows[i].a, got, rsp);
         chk(got, 0);
      end
      foreach (rows[i]) begin
         u_dlc_host_model.wr(rows[i].a, rows[i].d, rsp);
         chk(rsp, rows[i].r);
         u_dlc_host_model.rd(rows[i].a, got, rsp);
         chk(got, rows[i].q);
         chk(rsp, rows[i].r);
      end
      chk(cfg.lane_mask, 4'hf);
      chk(cfg.enh_framing, 1);
      chk(cfg.scr_bypass, 1);
      chk(cfg.mst_enable, 1);
      for (int i = 0; i < 4; i++) begin
         u_dlc_host_model.wr(OFF_TRAIN, i, rsp);
         chk(cfg.train, i);
         u_dlc_host_model.wr(OFF_QUAL, i, rsp);
         chk(cfg.qual, i);
      end
      for (int i = 0; i < 3; i++) begin
         u_dlc_host_model.wr(OFF_RATE, {RATE_162, RATE_270, RATE_540} >> (16 - 8 * i), rsp);
         chk({cfg.rate_sel, cfg.rate_valid}, {i[1:0], 1'b1});
      end
      chk(cfg.rate_code, RATE_540);
      u_dlc_host_model.wr(OFF_RATE, 32'h07, rsp);
      chk({cfg.rate_sel, cfg.rate_valid}, {DLC_RATE_BAD, 1'b0});
      pulse_chk(OFF_SOFTRST, 32'h81, 6'h06);
      pulse_chk(OFF_SOFTRST, 32'h0e, 6'h38);
      pulse_chk(OFF_SCRRST, 32'h1, 6'h01);
      chk(no_video_flag, 1);
      @(posedge mclk);
      #1;
      vid_vsync = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      vid_vsync = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk({stream_enable, no_video_flag}, 2'b10);
      u_dlc_host_model.wr(OFF_VIDEN, 0, rsp);
      repeat (4) @(posedge mclk);
      #1;
      chk(no_video_flag, 0);
      u_dlc_host_model.wr(OFF_TXEN, 0, rsp);
      chk({stream_enable, cfg.tx_enable}, 0);
      tg = cfg_toggle;
      u_dlc_host_model.wr(OFF_LANES, LANES_2, rsp);
      chk({cfg_toggle, cfg.lane_count, cfg.lane_mask}, {~tg, LANES_2, 4'h3});
      payload_updated = 1'b1;
      repeat (4) @(posedge mclk);
      u_dlc_host_model.rd(OFF_MST, got, rsp);
      chk(got, 32'h3);
      u_dlc_host_model.wr(OFF_MST, 0, rsp);
      u_dlc_host_model.rd(OFF_MST, got, rsp);
      chk({got, cfg.mst_enable}, {32'h2, 1'b0});
      // reset again in mid-run; the bank must fall back to its power-on state
      @(posedge mclk);
      #1;
      sys_rst = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      chk(cfg, '0);
      chk(no_video_flag, 1);
      u_dlc_host_model.rd(OFF_LANES, got, rsp);
      chk(got, 0);
      end_sim();
   end
endmodule : dlc_regs_tb
